// *** pkg/smie_pkg.sv ***
// shared constants for the shift / move / indirect-load execution block
// assumes one core clock; the register file and the decoder sit outside
package smie_pkg;

    // data path and address widths
    localparam int          DATA_W        = 8;
    localparam int          FILE_AW       = 7;
    localparam int          PTR_W         = 16;
    localparam int          OFS_W         = 6;

    // operation codes presented by the decoder
    localparam logic [1:0]  OP_SHIFT      = 2'h0;   // logical right shift through carry
    localparam logic [1:0]  OP_MOVE       = 2'h1;   // move file register, zero test
    localparam logic [1:0]  OP_INDIRECT   = 2'h2;   // indirect load into working reg
    localparam logic [1:0]  OP_NONE       = 2'h3;   // not served, ignored

    // pointer update codes for the indirect load
    localparam logic [1:0]  MODE_PRE_INC  = 2'h0;
    localparam logic [1:0]  MODE_PRE_DEC  = 2'h1;
    localparam logic [1:0]  MODE_POST_INC = 2'h2;
    localparam logic [1:0]  MODE_POST_DEC = 2'h3;

    // destination select
    localparam logic        DEST_WREG     = 1'b0;
    localparam logic        DEST_FILE     = 1'b1;

    // file addresses of the two indirect windows
    localparam logic [6:0]  WIN0_ADDR     = 7'h00;
    localparam logic [6:0]  WIN1_ADDR     = 7'h01;

    // reset values
    localparam logic [7:0]  WREG_RST      = 8'h00;
    localparam logic [15:0] PTR_RST       = 16'h0000;
    localparam logic        FLAG_RST      = 1'b0;

    // field positions of the shift
    localparam int          SHIFT_MSB     = 7;
    localparam int          SHIFT_LSB     = 0;

endpackage : smie_pkg

// *** src/smie_exec.sv ***
// execution logic for right shift, move-file and indirect load
// assumes a register file that answers a read one cycle after rdReq,
// and a decoder that holds each operation for one cycle on opValid
// the package supplies widths, codes, window addresses and reset values
// every output comes straight from a flip-flop of the state register
//
// timing of one operation, counted from the edge that takes it:
//   cycle 1  rdReq high, rdAddr holds the access address, busy high
//   cycle 2  the register file drives rdData, busy still high
//   cycle 3  opDone high, results and wrReq visible, busy low
// a new operation may be presented in cycle 3, so one op every three
// cycles; requests seen while busy are dropped, not queued
// pointer steps of the indirect load show already in cycle 1
//
// Function
// - shift right, zero into bit 7, bit 0 to carry
// - shift destination bit selects working or file register
// - move copies file register to chosen destination
// - move updates zero flag for both destinations
// - indirect load fills working register, updates zero
// - two-bit mode picks pre/post increment/decrement
// - offset form adds signed offset, pointer kept
// - pointer ends plus one, minus one or unchanged
// - two pointers chosen by one index bit
// - window access redirected to pointer's address
// - pointer wraps at both ends of its range
module smie_exec #(
    parameter int PTR_W = smie_pkg::PTR_W,
    parameter int OFS_W = smie_pkg::OFS_W
) (
    input  wire logic                      clk_sys,
    input  wire logic                      rst,
    // operation request from the decoder
    input  wire logic                      opValid,
    input  wire logic [1:0]                opCode,
    input  wire logic [smie_pkg::FILE_AW-1:0] fileAddr,
    input  wire logic                      destSel,
    input  wire logic                      ptrSel,
    input  wire logic [1:0]                ptrModeCode,
    input  wire logic                      offsetForm,
    input  wire logic [OFS_W-1:0]          relOffset,
    // direct pointer load from the core
    input  wire logic                      ptrLoad,
    input  wire logic                      ptrLoadSel,
    input  wire logic [PTR_W-1:0]          ptrLoadValue,
    // register file
    input  wire logic [smie_pkg::DATA_W-1:0] rdData,
    output logic                           rdReq,
    output logic [PTR_W-1:0]               rdAddr,
    output logic                           wrReq,
    output logic [PTR_W-1:0]               wrAddr,
    output logic [smie_pkg::DATA_W-1:0]    wrData,
    // architectural state
    output logic [smie_pkg::DATA_W-1:0]    wRegValue,
    output logic                           carryFlag,
    output logic                           zeroFlag,
    output logic [PTR_W-1:0]               ptr0Value,
    output logic [PTR_W-1:0]               ptr1Value,
    // progress
    output logic                           busy,
    output logic                           opDone
);

    // refuse widths the arithmetic cannot serve
    if (PTR_W < smie_pkg::FILE_AW || PTR_W > 16) begin : g_chk_ptr
        $error("smie_exec: PTR_W must lie between FILE_AW and 16");
    end
    if (OFS_W < 2 || OFS_W > PTR_W) begin : g_chk_ofs
        $error("smie_exec: OFS_W must lie between 2 and PTR_W");
    end
    // the shift slices and the zero test assume an 8-bit data word
    if (smie_pkg::DATA_W != 8) begin : g_chk_data
        $error("smie_exec: DATA_W must be 8");
    end
    if (smie_pkg::SHIFT_MSB != smie_pkg::DATA_W - 1 ||
        smie_pkg::SHIFT_LSB != 0) begin : g_chk_shift
        $error("smie_exec: shift field must span the data word");
    end
    // the two windows must decode to distinct file addresses
    if (smie_pkg::WIN0_ADDR == smie_pkg::WIN1_ADDR) begin : g_chk_win
        $error("smie_exec: window addresses must differ");
    end

    // one pointer step, sized to the pointer
    localparam logic [PTR_W-1:0] PTR_ONE = PTR_W'(1);

    // sequencer states, one-hot
    typedef enum logic [2:0] {
        ST_IDLE = 3'h1,
        ST_READ = 3'h2,
        ST_CAPT = 3'h4
    } smie_state_t;

    // every flip-flop of the block
    typedef struct packed {
        // sequencing
        smie_state_t                     state;
        logic [1:0]                      op;
        logic                            dest;
        // register-file access
        logic [PTR_W-1:0]                accAddr;
        logic                            rdReq;
        logic                            wrReq;
        logic [smie_pkg::DATA_W-1:0]     wrData;
        // working register and flags
        logic [smie_pkg::DATA_W-1:0]     wReg;
        logic                            carry;
        logic                            zero;
        // pointer pair
        logic [1:0][PTR_W-1:0]           ptr;
        // progress
        logic                            busy;
        logic                            done;
    } smie_regs_t;

    smie_regs_t st_q;
    smie_regs_t st_d;

    // zero test of an 8-bit result
    function automatic logic isZero(input logic [smie_pkg::DATA_W-1:0] v);
        isZero = (v == '0);
    endfunction : isZero

    // one step of a pointer; modular arithmetic wraps at both ends
    function automatic logic [PTR_W-1:0] stepPtr(input logic [PTR_W-1:0] p,
                                                 input logic             down);
        stepPtr = down ? (p - PTR_ONE) : (p + PTR_ONE);
    endfunction : stepPtr

    // signed offset widened to pointer width
    function automatic logic [PTR_W-1:0] signExt(input logic [OFS_W-1:0] k);
        signExt = {{(PTR_W - OFS_W){k[OFS_W-1]}}, k};
    endfunction : signExt

    // destination decode shared by shift and move
    function automatic logic destIsFile(input logic d);
        destIsFile = (d == smie_pkg::DEST_FILE);
    endfunction : destIsFile

    // next-state logic of the whole block
    // cur and nextPtr hold the selected pointer before and after its step,
    // addr the address of the read, res the 8-bit result of the operation
    // and toFile whether that result goes back to the file register;
    // all of them are cleared first so no latch is inferred
    always_comb begin
        logic [PTR_W-1:0]            cur;
        logic [PTR_W-1:0]            addr;
        logic [PTR_W-1:0]            nextPtr;
        logic [smie_pkg::DATA_W-1:0] res;
        logic                        toFile;
        cur     = '0;
        addr    = '0;
        nextPtr = '0;
        res     = '0;
        toFile  = 1'b0;
        // hold every field; strobes are one-cycle pulses cleared here
        st_d       = st_q;
        st_d.rdReq = 1'b0;
        st_d.wrReq = 1'b0;
        st_d.done  = 1'b0;
        unique case (st_q.state)
            ST_IDLE: begin
                // idle is the only state that takes a request
                if (opValid && opCode != smie_pkg::OP_NONE) begin
                    st_d.op    = opCode;
                    st_d.dest  = destSel;
                    st_d.state = ST_READ;
                    st_d.rdReq = 1'b1;
                    st_d.busy  = 1'b1;
                    if (opCode == smie_pkg::OP_INDIRECT) begin
                        // selected pointer before and after its step
                        cur     = st_q.ptr[ptrSel];
                        nextPtr = cur;
                        if (offsetForm) begin
                            // pointer itself is left alone
                            addr = cur + signExt(relOffset);
                        end else begin
                            unique case (ptrModeCode)
                                // pre modes access through the stepped value
                                smie_pkg::MODE_PRE_INC: begin
                                    nextPtr = stepPtr(cur, 1'b0);
                                    addr    = nextPtr;
                                end
                                smie_pkg::MODE_PRE_DEC: begin
                                    nextPtr = stepPtr(cur, 1'b1);
                                    addr    = nextPtr;
                                end
                                // post modes access through the old value
                                smie_pkg::MODE_POST_INC: begin
                                    nextPtr = stepPtr(cur, 1'b0);
                                    addr    = cur;
                                end
                                smie_pkg::MODE_POST_DEC: begin
                                    nextPtr = stepPtr(cur, 1'b1);
                                    addr    = cur;
                                end
                            endcase
                        end
                        st_d.ptr[ptrSel] = nextPtr;
                    end else if (fileAddr == smie_pkg::WIN0_ADDR) begin
                        // window has no storage: use the pointer's target
                        addr = st_q.ptr[0];
                    end else if (fileAddr == smie_pkg::WIN1_ADDR) begin
                        addr = st_q.ptr[1];
                    end else begin
                        addr = PTR_W'(fileAddr);
                    end
                    st_d.accAddr = addr;
                end else if (ptrLoad) begin
                    // direct load only when no operation is taken
                    st_d.ptr[ptrLoadSel] = ptrLoadValue;
                end
            end
            ST_READ: begin
                // register file answers during the next cycle
                st_d.state = ST_CAPT;
            end
            ST_CAPT: begin
                // form the result from the read answer
                unique case (st_q.op)
                    smie_pkg::OP_SHIFT: begin
                        // zero into the top, bottom bit out to carry
                        res        = {1'b0, rdData[smie_pkg::SHIFT_MSB:1]};
                        st_d.carry = rdData[smie_pkg::SHIFT_LSB];
                        toFile     = destIsFile(st_q.dest);
                    end
                    smie_pkg::OP_MOVE: begin
                        // copy as is; writing back to itself is a zero test
                        res    = rdData;
                        toFile = destIsFile(st_q.dest);
                    end
                    default: begin
                        // indirect load always lands in the working reg
                        res    = rdData;
                        toFile = 1'b0;
                    end
                endcase
                // zero flag follows the result for every operation here
                st_d.zero = isZero(res);
                // a file result leaves as a write, any other lands in the working reg
                if (toFile) begin
                    st_d.wrReq  = 1'b1;
                    st_d.wrData = res;
                end else begin
                    st_d.wReg   = res;
                end
                st_d.done  = 1'b1;
                st_d.busy  = 1'b0;
                st_d.state = ST_IDLE;
            end
            default: begin
                // illegal code: return to idle without side effects
                st_d.state = ST_IDLE;
                st_d.busy  = 1'b0;
            end
        endcase
    end

    // state register
    // asynchronous reset gives every field a constant value;
    // both pointers reset to the same value
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            // sequencing and strobes
            st_q.state   <= ST_IDLE;
            st_q.op      <= smie_pkg::OP_NONE;
            st_q.dest    <= smie_pkg::DEST_WREG;
            st_q.accAddr <= '0;
            st_q.rdReq   <= 1'b0;
            st_q.wrReq   <= 1'b0;
            // results and flags
            st_q.wrData  <= '0;
            st_q.wReg    <= smie_pkg::WREG_RST;
            st_q.carry   <= smie_pkg::FLAG_RST;
            st_q.zero    <= smie_pkg::FLAG_RST;
            // pointers and progress
            st_q.ptr     <= {2{PTR_W'(smie_pkg::PTR_RST)}};
            st_q.busy    <= 1'b0;
            st_q.done    <= 1'b0;
        end else begin
            st_q <= st_d;
        end
    end

    // outputs straight from the state register
    // register-file strobes and address
    assign rdReq     = st_q.rdReq;
    assign rdAddr    = st_q.accAddr;
    assign wrReq     = st_q.wrReq;
    assign wrAddr    = st_q.accAddr;  // write-back goes where the read came from
    assign wrData    = st_q.wrData;

    // architectural state
    assign wRegValue = st_q.wReg;
    assign carryFlag = st_q.carry;
    assign zeroFlag  = st_q.zero;
    assign ptr0Value = st_q.ptr[0];
    assign ptr1Value = st_q.ptr[1];

    // progress
    assign busy      = st_q.busy;
    assign opDone    = st_q.done;

endmodule : smie_exec

// *** sim/smie_exec_props.sv ***
// concurrent checks on the ports of the execution block
// bound into every smie_exec instance; one core clock, async reset
module smie_exec_props #(
    parameter int PTR_W = smie_pkg::PTR_W,
    parameter int OFS_W = smie_pkg::OFS_W
) (
    input wire logic             clk_sys,
    input wire logic             rst,
    input wire logic             opValid,
    input wire logic [1:0]       opCode,
    input wire logic [6:0]       fileAddr,
    input wire logic             destSel,
    input wire logic             ptrSel,
    input wire logic [1:0]       ptrModeCode,
    input wire logic             offsetForm,
    input wire logic [OFS_W-1:0] relOffset,
    input wire logic [7:0]       rdData,
    input wire logic             rdReq,
    input wire logic [PTR_W-1:0] rdAddr,
    input wire logic             wrReq,
    input wire logic [7:0]       wrData,
    input wire logic [7:0]       wRegValue,
    input wire logic             carryFlag,
    input wire logic             zeroFlag,
    input wire logic [PTR_W-1:0] ptr0Value,
    input wire logic [PTR_W-1:0] ptr1Value,
    input wire logic             busy,
    input wire logic             opDone
);
    logic             take;
    logic             ind;
    logic [PTR_W-1:0] inc0;
    logic [PTR_W-1:0] dec1;
    logic [PTR_W-1:0] ofs0;
    // request accepted, next pointer values and the offset address
    assign take = opValid && !busy && opCode != smie_pkg::OP_NONE;
    assign ind  = take && opCode == smie_pkg::OP_INDIRECT;
    assign inc0 = ptr0Value + 1'b1;
    assign dec1 = ptr1Value - 1'b1;
    assign ofs0 = ptr0Value + PTR_W'($signed(relOffset));
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    // operation steps up to the read answer
    sequence shiftFile;
        take && opCode == smie_pkg::OP_SHIFT && destSel ##2 1'b1;
    endsequence
    sequence moveWreg;
        take && opCode == smie_pkg::OP_MOVE && !destSel ##2 1'b1;
    endsequence
    sequence zeroOp;
        take && opCode != smie_pkg::OP_SHIFT ##2 1'b1;
    endsequence
    AST_ISSUE: assert property (take |=> rdReq && busy ##1 busy ##1 opDone && !busy)
        else $error("operation timing wrong");
    AST_SHIFT: assert property (shiftFile |=> wrReq && wrData == {1'b0, $past(rdData[7:1])}
        && carryFlag == $past(rdData[0])) else $error("shift result wrong");
    AST_MOVE: assert property (moveWreg |=> wRegValue == $past(rdData) && !wrReq)
        else $error("move to working reg wrong");
    AST_ZERO: assert property (zeroOp |=> zeroFlag == ($past(rdData) == 8'h00))
        else $error("zero flag wrong");
    AST_WIN: assert property (take && !ind && fileAddr == smie_pkg::WIN0_ADDR
        |=> rdAddr == $past(ptr0Value)) else $error("window not redirected");
    AST_PREINC: assert property (ind && !offsetForm && !ptrSel && ptrModeCode == 2'h0
        |=> rdAddr == $past(inc0) && ptr0Value == $past(inc0)) else $error("pre-inc wrong");
    AST_POSTDEC: assert property (ind && !offsetForm && ptrSel && ptrModeCode == 2'h3
        |=> rdAddr == $past(ptr1Value) && ptr1Value == $past(dec1)) else $error("post-dec wrong");
    AST_OFFSET: assert property (ind && offsetForm && !ptrSel
        |=> rdAddr == $past(ofs0) ##0 $stable(ptr0Value) [*3]) else $error("offset wrong");
endmodule : smie_exec_props

bind smie_exec smie_exec_props #(.PTR_W(PTR_W), .OFS_W(OFS_W)) i_smie_exec_props (
    .clk_sys, .rst, .opValid, .opCode, .fileAddr, .destSel, .ptrSel, .ptrModeCode, .offsetForm,
    .relOffset, .rdData, .rdReq, .rdAddr, .wrReq, .wrData, .wRegValue, .carryFlag, .zeroFlag,
    .ptr0Value, .ptr1Value, .busy, .opDone);

// *** sim/smie_exec_bench.sv ***
// self-checking bench for the execution block
// drives decoder, pointer-load and register-file ports itself
module smie_exec_bench;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk_sys = 1'b0, rst = 1'b1, opValid = 1'b0, destSel = 1'b0, ptrSel = 1'b0;
    logic        offsetForm = 1'b0, ptrLoad = 1'b0, ptrLoadSel = 1'b0;
    logic [1:0]  opCode = 2'h0, ptrModeCode = 2'h0;
    logic [6:0]  fileAddr = 7'h00;
    logic [5:0]  relOffset = 6'h00;
    logic [7:0]  rdData = 8'h00, wrData, wRegValue;
    logic [15:0] ptrLoadValue = 16'h0000, rdAddr, wrAddr, ptr0Value, ptr1Value, addr1, p;
    logic        rdReq, wrReq, carryFlag, zeroFlag, busy, opDone;
    int          n_fail = 0, comparisons = 0;
    smie_exec i_smie_exec (.clk_sys, .rst, .opValid, .opCode, .fileAddr, .destSel, .ptrSel,
        .ptrModeCode, .offsetForm, .relOffset, .ptrLoad, .ptrLoadSel, .ptrLoadValue, .rdData,
        .rdReq, .rdAddr, .wrReq, .wrAddr, .wrData, .wRegValue, .carryFlag, .zeroFlag,
        .ptr0Value, .ptr1Value, .busy, .opDone);
    // clock and watchdog
    initial forever #50 clk_sys = ~clk_sys;
    initial begin
        #200000;
        n_fail++;
        stop_test();
    end
    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    // one operation: request, read answer rd, then sample in the done cycle
    task automatic op(input logic [1:0] c, input logic [6:0] fa, input logic d, input logic s,
                      input logic [1:0] m, input logic f, input logic [5:0] k, input logic [7:0] rd);
        opCode = c;
        fileAddr = fa;
        destSel = d;
        ptrSel = s;
        ptrModeCode = m;
        offsetForm = f;
        relOffset = k;
        opValid = 1'b1;
        @(posedge clk_sys);
        #1;
        opValid = 1'b0;
        addr1 = rdAddr;
        repeat (2) @(posedge clk_sys) #1 rdData = rd;
        chk("opDone", opDone, 1'b1);
        rdData = ~rd;
    endtask : op
    task automatic load(input logic s, input logic [15:0] v);
        ptrLoadSel = s;
        ptrLoadValue = v;
        ptrLoad = 1'b1;
        @(posedge clk_sys);
        #1;
        ptrLoad = 1'b0;
    endtask : load
    task automatic t_shift_move();
        op(smie_pkg::OP_SHIFT, 7'h20, 1'b1, 1'b0, 2'h0, 1'b0, 6'h00, 8'h81);
        chk("addr", addr1, 16'h0020);
        chk("wrData", wrData, 8'h40);
        chk("carry", carryFlag, 1'b1);
        chk("wrReq", wrReq, 1'b1);
        chk("wrAddr", wrAddr, 16'h0020);
        chk("zero", zeroFlag, 1'b0);
        op(smie_pkg::OP_SHIFT, 7'h21, 1'b0, 1'b0, 2'h0, 1'b0, 6'h00, 8'h01);
        chk("wReg", wRegValue, 8'h00);
        chk("zero", zeroFlag, 1'b1);
        op(smie_pkg::OP_MOVE, 7'h22, 1'b0, 1'b0, 2'h0, 1'b0, 6'h00, 8'h5A);
        chk("wReg", wRegValue, 8'h5A);
        chk("zero", zeroFlag, 1'b0);
        op(smie_pkg::OP_MOVE, 7'h23, 1'b1, 1'b0, 2'h0, 1'b0, 6'h00, 8'h00);
        chk("wrReq", wrReq, 1'b1);
        chk("wrAddr", wrAddr, 16'h0023);
        chk("zero", zeroFlag, 1'b1);
        chk("wReg", wRegValue, 8'h5A);
    endtask : t_shift_move
    task automatic t_pointer();
        load(1'b0, 16'h1000);
        load(1'b1, 16'hFFFF);
        p = 16'h1000;
        for (int m = 0; m < 4; m++) begin
            op(smie_pkg::OP_INDIRECT, 7'h00, 1'b0, 1'b0, 2'(m), 1'b0, 6'h00, 8'(m));
            chk("addr", addr1, m[1] ? p : (m[0] ? p - 1'b1 : p + 1'b1));
            p = m[0] ? p - 1'b1 : p + 1'b1;
            chk("ptr0", ptr0Value, p);
            chk("wReg", wRegValue, 8'(m));
        end
        op(smie_pkg::OP_INDIRECT, 7'h00, 1'b0, 1'b1, 2'h0, 1'b0, 6'h00, 8'h33);
        chk("wrap", ptr1Value, 16'h0000);
        op(smie_pkg::OP_INDIRECT, 7'h00, 1'b0, 1'b1, 2'h3, 1'b0, 6'h00, 8'h44);
        chk("wrap", ptr1Value, 16'hFFFF);
        op(smie_pkg::OP_INDIRECT, 7'h00, 1'b0, 1'b0, 2'h0, 1'b1, 6'h20, 8'h55);
        chk("ofs", addr1, p - 16'h0020);
        op(smie_pkg::OP_INDIRECT, 7'h00, 1'b0, 1'b0, 2'h1, 1'b1, 6'h1F, 8'h66);
        chk("ofs", addr1, p + 16'h001F);
        chk("ptr0", ptr0Value, p);
        op(smie_pkg::OP_SHIFT, smie_pkg::WIN1_ADDR, 1'b0, 1'b0, 2'h0, 1'b0, 6'h00, 8'h02);
        chk("win1", addr1, 16'hFFFF);
        op(smie_pkg::OP_MOVE, smie_pkg::WIN0_ADDR, 1'b0, 1'b0, 2'h0, 1'b0, 6'h00, 8'h02);
        chk("win0", addr1, p);
    endtask : t_pointer
    // an unserved code is dropped; a pointer load beside a taken op is ignored
    task automatic t_refused();
        opCode = smie_pkg::OP_NONE;
        opValid = 1'b1;
        @(posedge clk_sys);
        #1;
        opValid = 1'b0;
        chk("busy", busy, 1'b0);
        chk("rdReq", rdReq, 1'b0);
        chk("wReg", wRegValue, 8'h02);
        ptrLoadSel = 1'b0;
        ptrLoadValue = 16'hABCD;
        ptrLoad = 1'b1;
        op(smie_pkg::OP_INDIRECT, 7'h00, 1'b0, 1'b0, 2'h2, 1'b0, 6'h00, 8'h77);
        ptrLoad = 1'b0;
        chk("ptr0", ptr0Value, p + 16'h0001);
        chk("wReg", wRegValue, 8'h77);
    endtask : t_refused
    task automatic stop_test();
        $display("comparisons %0d n_fail %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : stop_test
    // reset, then the scenarios
    initial begin
        repeat (16) @(posedge clk_sys);
        #1;
        rst = 1'b0;
        t_shift_move();
        t_pointer();
        t_refused();
        stop_test();
    end
endmodule : smie_exec_bench
